// file: logic/adc_ctrl_pkg.sv
// Contract
// - High result register returns result bits 9:2 in its bits 7:0.
// - Low result register holds result bits 1:0; its bits 7:2 read zero.
// - Setting converter_on starts back-to-back conversions of a channel.
// - Clearing converter_on disables the converter and stops conversion.
// - A finished conversion sets bit 7 and publishes the result.
// - A high register read or control/status write clears bit 7.
// - A new channel_select aborts, clears end-of-conversion, restarts.
// - A low read locks both results; high read or converter off unlocks.
// - Locked results stay unchanged until a high read or converter off unlocks them.
// - Clock bits slow,speed: 00 /2, 01 /1, 10 /4, 11 /2.
// - channel_select value n selects analog input n, for n from 0 to 15.
// - Over-range gives FFh high and 03h low; under-range gives all zeros.
// - Control/status bit 7 is read-only; bits 6:0 are read-write.
// - Wait has no effect; halt disables, wake-up needs a settling time.
`default_nettype none

package adc_ctrl_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [9:0]  IDX_CSR   = 10'h045;
  localparam logic [9:0]  IDX_HIGH  = 10'h046;
  localparam logic [9:0]  IDX_LOW   = 10'h047;
  localparam logic [9:0]  IDX_ISTAT = 10'h048;
  localparam logic [9:0]  IDX_IMASK = 10'h049;
  localparam logic [11:0] ADDR_CSR   = {IDX_CSR, 2'b00};
  localparam logic [11:0] ADDR_HIGH  = {IDX_HIGH, 2'b00};
  localparam logic [11:0] ADDR_LOW   = {IDX_LOW, 2'b00};
  localparam logic [11:0] ADDR_ISTAT = {IDX_ISTAT, 2'b00};
  localparam logic [11:0] ADDR_IMASK = {IDX_IMASK, 2'b00};

  localparam int unsigned CSR_EOC_BIT   = 7;
  localparam int unsigned CSR_SPEED_BIT = 6;
  localparam int unsigned CSR_ON_BIT    = 5;
  localparam int unsigned CSR_SLOW_BIT  = 4;
  localparam int unsigned CSR_CH_LSB    = 0;
  localparam int unsigned CH_W          = 4;

  localparam logic [6:0] CSR_CTL_RESET = 7'h00;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;

  localparam int unsigned EV_EOC = 0;
  localparam int unsigned EV_OVR = 1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned STAB_TIME_NS  = 2000;
  localparam int unsigned STAB_CYCLES   =
    (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STAB_LAST   = 8'(STAB_CYCLES - 1);
  localparam logic [3:0] SAMPLE_LAST = 4'h3;
  localparam logic [3:0] BIT_TOP     = 4'h9;
  localparam logic [9:0] SAR_FIRST   = 10'h200;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef enum logic [3:0] {
    CONV_OFF    = 4'b0001,
    CONV_STAB   = 4'b0010,
    CONV_SAMPLE = 4'b0100,
    CONV_BITS   = 4'b1000
  } conv_state_t;

  typedef struct packed {
    logic [6:0]  ctl;
    logic        eoc;
    logic [7:0]  res_high;
    logic [1:0]  res_low;
    logic        locked;
    logic        halted;
    conv_state_t fsm;
    logic [1:0]  div_cnt;
    logic [3:0]  step;
    logic [7:0]  stab_cnt;
    logic [9:0]  sar;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] prdata;
    logic        rd_ok;
  } adc_state_t;

endpackage

`default_nettype wire

// file: logic/sar_adc_control_logic.sv
`timescale 1ns/1ns
`default_nettype none

module sar_adc_control_logic
  import adc_ctrl_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire apb_req_t   apb_req,
  output var  apb_rsp_t   apb_rsp,
  input  wire logic       halt_mode,
  input  wire logic       comp_in,
  output var  logic       adc_power,
  output var  logic [3:0] adc_channel,
  output var  logic       adc_sample,
  output var  logic [9:0] dac_code,
  output var  logic       irq
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  adc_state_t  st_reg;
  adc_state_t  st_next;
  logic        hit_csr;
  logic        hit_high;
  logic        hit_low;
  logic        hit_stat;
  logic        hit_mask;
  logic        mapped;
  logic        ready;
  logic        rd_acc;
  logic        wr_acc;
  logic [31:0] rd_mux;
  logic [1:0]  div_last;
  logic        tick;

  assign hit_csr  = apb_req.paddr == ADDR_CSR;
  assign hit_high = apb_req.paddr == ADDR_HIGH;
  assign hit_low  = apb_req.paddr == ADDR_LOW;
  assign hit_stat = apb_req.paddr == ADDR_ISTAT;
  assign hit_mask = apb_req.paddr == ADDR_IMASK;
  assign mapped   = hit_csr | hit_high | hit_low | hit_stat | hit_mask;

  // Read data is captured in the setup cycle, so the access phase is ready.
  assign ready  = apb_req.psel & apb_req.penable & clk_en & st_reg.rd_ok;
  assign rd_acc = ready & ~apb_req.pwrite & mapped;
  assign wr_acc = ready & apb_req.pwrite & mapped;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_csr)
      rd_mux[7:0] = {st_reg.eoc, st_reg.ctl};
    if (hit_high)
      rd_mux[7:0] = st_reg.res_high;
    if (hit_low)
      rd_mux[7:0] = {6'h00, st_reg.res_low};
    if (hit_stat)
      rd_mux[1:0] = st_reg.irq_stat;
    if (hit_mask)
      rd_mux[1:0] = st_reg.irq_mask;
  end

  // ==========================================================================
  // Conversion clock divider
  // ==========================================================================
  always_comb begin
    unique case ({st_reg.ctl[CSR_SLOW_BIT], st_reg.ctl[CSR_SPEED_BIT]})
      2'b00:   div_last = 2'h1;
      2'b01:   div_last = 2'h0;
      2'b10:   div_last = 2'h3;
      2'b11:   div_last = 2'h1;
      default: div_last = 2'h1;
    endcase
  end

  assign tick = st_reg.div_cnt == div_last;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic       done;
    logic [9:0] sar_n;
    logic       new_on;
    logic [3:0] new_ch;
    done    = 1'b0;
    sar_n   = st_reg.sar;
    new_on  = apb_req.pwdata[CSR_ON_BIT];
    new_ch  = apb_req.pwdata[CSR_CH_LSB +: CH_W];
    st_next = st_reg;

    st_next.div_cnt = tick ? 2'h0 : 2'(st_reg.div_cnt + 2'h1);

    // Conversion sequencer: fixed sample window then ten bit trials.
    unique case (st_reg.fsm)
      CONV_OFF: begin
        if (st_reg.ctl[CSR_ON_BIT] && !halt_mode) begin
          st_next.fsm      = st_reg.halted ? CONV_STAB : CONV_SAMPLE;
          st_next.halted   = 1'b0;
          st_next.stab_cnt = 8'h00;
          st_next.step     = 4'h0;
          st_next.div_cnt  = 2'h0;
        end
      end
      CONV_STAB: begin
        st_next.stab_cnt = 8'(st_reg.stab_cnt + 8'h01);
        if (st_reg.stab_cnt == STAB_LAST) begin
          st_next.fsm     = CONV_SAMPLE;
          st_next.step    = 4'h0;
          st_next.div_cnt = 2'h0;
        end
      end
      CONV_SAMPLE: begin
        if (tick) begin
          st_next.step = 4'(st_reg.step + 4'h1);
          if (st_reg.step == SAMPLE_LAST) begin
            st_next.fsm  = CONV_BITS;
            st_next.step = BIT_TOP;
            st_next.sar  = SAR_FIRST;
          end
        end
      end
      CONV_BITS: begin
        if (tick) begin
          // Comparator high keeps the trial bit; a saturated input ends
          // at 3ffh and an input below range at zero.
          if (!comp_in)
            sar_n[st_reg.step] = 1'b0;
          if (st_reg.step == 4'h0) begin
            done         = 1'b1;
            st_next.fsm  = CONV_SAMPLE;
          end else begin
            sar_n[4'(st_reg.step - 4'h1)] = 1'b1;
            st_next.step = 4'(st_reg.step - 4'h1);
          end
          st_next.sar = sar_n;
        end
      end
      default: st_next.fsm = CONV_OFF;
    endcase

    // Halt powers the converter down; wait mode has no input here.
    if (halt_mode && st_reg.fsm != CONV_OFF) begin
      st_next.fsm    = CONV_OFF;
      st_next.halted = 1'b1;
      done           = 1'b0;
    end

    // Register side effects.
    if (rd_acc && hit_high) begin
      st_next.eoc    = 1'b0;
      st_next.locked = 1'b0;
    end
    if (rd_acc && hit_low)
      st_next.locked = 1'b1;

    if (wr_acc && hit_csr) begin
      st_next.ctl = apb_req.pwdata[6:0];
      st_next.eoc = 1'b0;
      if (!new_on) begin
        st_next.fsm    = CONV_OFF;
        st_next.locked = 1'b0;
        st_next.halted = 1'b0;
        done           = 1'b0;
      end else if (new_ch != st_reg.ctl[CSR_CH_LSB +: CH_W] &&
                   st_reg.fsm != CONV_OFF &&
                   st_next.fsm != CONV_OFF) begin
        st_next.fsm     = CONV_SAMPLE;
        st_next.step    = 4'h0;
        st_next.div_cnt = 2'h0;
        done            = 1'b0;
      end
    end

    if (wr_acc && hit_stat)
      st_next.irq_stat = st_reg.irq_stat & ~apb_req.pwdata[1:0];
    if (wr_acc && hit_mask)
      st_next.irq_mask = apb_req.pwdata[1:0];

    // Completion comes last so that its set beats any clear this cycle.
    if (done) begin
      st_next.eoc              = 1'b1;
      st_next.irq_stat[EV_EOC] = 1'b1;
      if (!st_next.locked) begin
        st_next.res_high = sar_n[9:2];
        st_next.res_low  = sar_n[1:0];
      end else begin
        st_next.irq_stat[EV_OVR] = 1'b1;
      end
    end

    if (apb_req.psel && !apb_req.penable) begin
      st_next.prdata = rd_mux;
      st_next.rd_ok  = 1'b1;
    end
    if (ready)
      st_next.rd_ok = 1'b0;

    if (!clk_en)
      st_next = st_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{ctl:      CSR_CTL_RESET,
                  eoc:      1'b0,
                  res_high: RESULT_RESET,
                  res_low:  2'h0,
                  locked:   1'b0,
                  halted:   1'b0,
                  fsm:      CONV_OFF,
                  div_cnt:  2'h0,
                  step:     4'h0,
                  stab_cnt: 8'h00,
                  sar:      10'h000,
                  irq_stat: IRQ_RESET,
                  irq_mask: IRQ_RESET,
                  prdata:   32'h0000_0000,
                  rd_ok:    1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign apb_rsp.prdata  = st_reg.prdata;
  assign apb_rsp.pready  = ready;
  assign apb_rsp.pslverr = ready & ~mapped;

  assign adc_power   = st_reg.fsm != CONV_OFF;
  assign adc_channel = st_reg.ctl[CSR_CH_LSB +: CH_W];
  assign adc_sample  = st_reg.fsm == CONV_SAMPLE;
  assign dac_code    = (st_reg.fsm == CONV_BITS) ? st_reg.sar : 10'h000;
  assign irq         = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule

`default_nettype wire

// file: dv/adc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none

module adc_analog_model
  import adc_ctrl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              adc_power,
  input  wire logic [3:0]        adc_channel,
  input  wire logic [9:0]        dac_code,
  input  wire logic [15:0][10:0] level,
  output var  logic              comp_in
);
  // ===========================================================================
  // Comparator
  // ===========================================================================
  logic wander = 1'b0;

  // A powered-down comparator gives no steady answer.
  always @(posedge pclk) wander <= ~wander;

  always_comb begin
    if (adc_power) begin
      comp_in = level[adc_channel] >= {1'b0, dac_code};
    end else begin
      comp_in = wander;
    end
  end
endmodule

`default_nettype wire

// file: dv/adc_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none

module adc_ctrl_sva
  import adc_ctrl_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       clk_en,
  input wire apb_req_t   apb_req,
  input wire apb_rsp_t   apb_rsp,
  input wire logic       halt_mode,
  input wire logic       adc_power,
  input wire logic [3:0] adc_channel,
  input wire logic       adc_sample,
  input wire logic [9:0] dac_code,
  input wire logic       irq
);
  // ===========================================================================
  // Properties
  // ===========================================================================
  logic acc, rd, wr_csr, mapped;
  assign acc = apb_rsp.pready && apb_req.psel && apb_req.penable;
  assign rd = acc && !apb_req.pwrite;
  assign wr_csr = acc && apb_req.pwrite && apb_req.paddr == ADDR_CSR;
  assign mapped = apb_req.paddr inside {ADDR_CSR, ADDR_HIGH, ADDR_LOW,
                                        ADDR_ISTAT, ADDR_IMASK};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_needs_req: assert property (
    apb_rsp.pready |-> apb_req.psel && apb_req.penable && clk_en)
    else $error("pready without a request");
  a_err_unmapped: assert property (
    acc |-> apb_rsp.pslverr == !mapped)
    else $error("pslverr does not match the address map");
  a_low_reserved: assert property (
    rd && apb_req.paddr == ADDR_LOW |-> apb_rsp.prdata[31:2] == 30'h0)
    else $error("low result upper bits set");
  a_high_width: assert property (
    rd && apb_req.paddr == ADDR_HIGH |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("high result too wide");
  a_chan_follows: assert property (
    wr_csr |=> adc_channel == $past(apb_req.pwdata[3:0]))
    else $error("channel wrong");
  a_on_starts: assert property (
    wr_csr && apb_req.pwdata[CSR_ON_BIT] && !adc_power && !halt_mode
    |-> ##[1:2] adc_power && adc_sample)
    else $error("no start");
  a_off_stops: assert property (
    wr_csr && !apb_req.pwdata[CSR_ON_BIT] |-> ##[1:2] !adc_power)
    else $error("converter still on");
  a_first_trial: assert property (
    $fell(adc_sample) && adc_power |-> dac_code == SAR_FIRST)
    else $error("first trial code wrong");
  a_halt_off: assert property (
    halt_mode |-> ##[0:2] !adc_power)
    else $error("converter runs in halt");
  a_freeze_state: assert property (
    !clk_en |=> $stable(dac_code) && $stable(adc_sample) &&
    $stable(adc_channel))
    else $error("not frozen");

  c_start: cover property (wr_csr && apb_req.pwdata[5]);
  c_read_low: cover property (rd && apb_req.paddr == ADDR_LOW);
  c_irq: cover property ($rose(irq));
  c_halt: cover property (halt_mode && $past(adc_power));
endmodule

bind sar_adc_control_logic adc_ctrl_sva sva_u (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .halt_mode(halt_mode), .adc_power(adc_power), .adc_channel(adc_channel),
  .adc_sample(adc_sample), .dac_code(dac_code), .irq(irq));

`default_nettype wire

// file: dv/sar_adc_control_logic_test.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end

module sar_adc_control_logic_test
  import adc_ctrl_pkg::*;
;
  // ===========================================================================
  // Bench
  // ===========================================================================
  logic pclk, presetn, clk_en, halt_mode, comp_in, adc_power, adc_sample, irq;
  apb_req_t req;
  apb_rsp_t rsp;
  logic [3:0]        adc_channel;
  logic [9:0]        dac_code;
  logic [15:0][10:0] level;
  logic [31:0]       seed, r, lo, hi;
  logic [3:0]        ch;
  logic [1:0]        mode;
  logic [10:0]       lv;
  int checks = 0, failures = 0, run_len = 0, last_len = 0, n;

  sar_adc_control_logic dut_u (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp), .halt_mode(halt_mode),
    .comp_in(comp_in), .adc_power(adc_power), .adc_channel(adc_channel),
    .adc_sample(adc_sample), .dac_code(dac_code), .irq(irq));
  adc_analog_model model_u (.pclk(pclk), .adc_power(adc_power),
    .adc_channel(adc_channel), .dac_code(dac_code), .level(level),
    .comp_in(comp_in));

  always #10 pclk = ~pclk;

  // Length of the most recent complete sample window, in pclk cycles.
  always @(posedge pclk) begin
    if (adc_sample === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int div(input logic slow, input logic speed);
    return ({slow, speed} == 2'b01) ? 1 : ({slow, speed} == 2'b10) ? 4 : 2;
  endfunction

  function automatic logic [9:0] code_of(input logic [10:0] v);
    return v[10] ? 10'h3ff : v[9:0];
  endfunction

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    if (rsp.pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    q = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_eoc;
    for (int k = 0; k < 100; k++) begin
      apb(1'b0, ADDR_CSR, 32'h0, r);
      if (r[7] === 1'b1) return;
    end
    failures++;
    finish_test();
  endtask

  initial begin
    pclk = 0; presetn = 0; clk_en = 1; halt_mode = 0; req = '0; level = '0;
    seed = 32'h947c5589;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_CSR, 0, r); `CHK(r, 32'h0)
    apb(0, ADDR_HIGH, 0, r); `CHK(r, 32'h0)
    apb(0, ADDR_LOW, 0, r); `CHK(r, 32'h0)
    apb(0, 12'h200, 0, r); `CHK(r, 32'h0)
    apb(1, ADDR_CSR, 32'hff, r);
    apb(0, ADDR_CSR, 0, r); `CHK(r, 32'h7f)
    $display("reset and access test done");
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      ch = seed[3:0];
      // All four divider settings are run in turn, three conversions each.
      mode = 2'(i);
      lv = (i == 0) ? 11'h0 : (i == 1) ? 11'h7ff : (i == 2) ? 11'h3ff
         : seed[14:4];
      apb(1, ADDR_CSR, 32'h0, r);
      level[ch] <= lv;
      apb(1, ADDR_CSR, {24'h0, 1'b0, mode[0], 1'b1, mode[1], ch}, r);
      wait_eoc();
      apb(0, ADDR_LOW, 0, lo);
      apb(0, ADDR_HIGH, 0, hi);
      `CHK({hi[7:0], lo[1:0]}, code_of(lv))
      `CHK(lo[7:2], 6'h0)
      `CHK(last_len, 4 * div(mode[1], mode[0]))
      if (mode == 2'b10) begin
        apb(0, ADDR_CSR, 0, r); `CHK(r[7], 1'b0)
      end
    end
    $display("conversion test done");
    apb(1, ADDR_IMASK, 32'h0, r);
    apb(1, ADDR_CSR, 32'h0, r);
    level[5] <= 11'h155;
    apb(1, ADDR_CSR, 32'h25, r);
    wait_eoc();
    apb(0, ADDR_LOW, 0, lo);
    level[5] <= 11'h2aa;
    repeat (200) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(0, ADDR_ISTAT, 0, r); `CHK(r[1:0], 2'b11)
    apb(1, ADDR_IMASK, 32'h3, r); `CHK(irq, 1'b1)
    apb(0, ADDR_HIGH, 0, hi); `CHK({hi[7:0], lo[1:0]}, 10'h155)
    wait_eoc();
    apb(0, ADDR_HIGH, 0, hi); `CHK(hi[7:0], 8'haa)
    apb(1, ADDR_CSR, 32'h05, r);
    apb(1, ADDR_ISTAT, 32'h3, r);
    apb(0, ADDR_ISTAT, 0, r); `CHK(r[1:0], 2'b00)
    `CHK(irq, 1'b0)
    $display("lock and interrupt test done");
    level[1] <= 11'h0c0;
    level[2] <= 11'h300;
    apb(1, ADDR_CSR, 32'h21, r);
    wait_eoc();
    apb(1, ADDR_CSR, 32'h22, r);
    apb(0, ADDR_CSR, 0, r); `CHK(r[7:0], 8'h22)
    wait_eoc();
    apb(0, ADDR_HIGH, 0, hi); `CHK(hi[7:0], 8'hc0)
    wait_eoc();
    apb(1, ADDR_CSR, 32'h22, r);
    apb(0, ADDR_CSR, 0, r); `CHK(r[7], 1'b0)
    $display("channel test done");
    halt_mode <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK(adc_power, 1'b0)
    halt_mode <= 1'b0;
    n = 0;
    while (adc_sample !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= 100 && n < 400, 1'b1)
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      clk_en <= seed[0];
      @(posedge pclk);
    end
    clk_en <= 1'b1;
    wait_eoc();
    apb(0, ADDR_HIGH, 0, hi); `CHK(hi[7:0], 8'hc0)
    $display("halt and clock enable test done");
    finish_test();
  end
endmodule

`default_nettype wire
